/* pvps_defines.svh */
// constants of the supply-programming serial slave: address, codes, defaults
// assumes inclusion by bare name from the design modules pvps_rx and pvps_top
`ifndef PVPS_DEFINES_SVH
`define PVPS_DEFINES_SVH
// fixed upper address bits A7..A2 (seven-bit address plus direction bit)
`define PVPS_ADDR_HI 6'h0A
// position of the target-select bit in the command byte
`define PVPS_TGT_BIT 5
// power-up core code (1.3 V) and sim code (0 V)
`define PVPS_CORE_RST 5'h18
`define PVPS_SIM_RST 2'h0
// number of bits in one address or data byte
`define PVPS_BYTE_BITS 4'h8
`endif

/* pvps_pkg.sv */
// types shared by the supply-programming serial slave
// does not include the defines header and uses none of its constants
package pvps_pkg;
  // link-side sequencer states, one-hot
  typedef enum logic [3:0]
  {
    PVPS_IDLE = 4'h1,
    PVPS_ADDR = 4'h2,
    PVPS_DATA = 4'h4,
    PVPS_ACK = 4'h8
  } pvps_state_e;
endpackage : pvps_pkg

/* pvps_link_if.sv */
// carrier between the link-side receiver and the system-side top
// assumes both ends share one instance made inside the top
`timescale 1ns/1ns
interface pvps_link_if;
  logic cmd_tgl;        // toggles once per accepted command byte (link domain)
  logic [7:0] cmd_byte; // command byte, stable while toggle is seen
  logic start_seen;     // level: a start condition was observed since enable
  modport rx (output cmd_tgl, output cmd_byte, output start_seen);
  modport sys (input cmd_tgl, input cmd_byte, input start_seen);
endinterface : pvps_link_if

/* pvps_rx.sv */
// link-side receiver of the supply-programming slave, clocked by the bus clock
// assumes i_rst_n is held low while the interface is disabled; the bus clock runs ungated
`timescale 1ns/1ns
`include "pvps_defines.svh"
module pvps_rx
  import pvps_pkg::*;
(
  // bus clock and the enable-qualified reset
  input wire logic i_scl,
  input wire logic i_rst_n,
  // bus data and strap
  input wire logic i_sda,
  input wire logic i_strap,
  output logic o_sda_oe,
  pvps_link_if.rx lnk
);
  logic start_q;            // start seen; set by the first start and held until reset
  logic stop_q;             // stop seen, toggled via sda rise
  logic start_tg_q;         // toggles on each start
  logic start_ack_q;        // scl-side copy of start toggle
  pvps_state_e state_q;     // receiver sequencer
  logic [3:0] cnt_q;        // bit counter within byte
  logic [7:0] sh_q;         // shift register
  logic is_addr_q;          // the ack slot follows the address byte
  logic [6:0] my_addr;      // own address, strap in A1
  logic cmd_tgl_q;
  logic [7:0] cmd_q;
  logic sda_oe_q;

  assign my_addr = {`PVPS_ADDR_HI, i_strap};
  assign lnk.cmd_tgl = cmd_tgl_q;
  assign lnk.cmd_byte = cmd_q;
  assign lnk.start_seen = start_q;
  assign o_sda_oe = sda_oe_q;

  // (RULE9) start detect
  // sda falling while scl high; the sda edge is the only clock that sees it
  always_ff @(negedge i_sda or negedge i_rst_n)
  begin
    if (!i_rst_n)
      start_tg_q <= 1'b0;
    else if (i_scl)
      start_tg_q <= ~start_tg_q;
  end

  // (RULE9) stop detect
  // a rise with scl high frees the bus; toggles stop_q on each stop, and reset clears it
  always_ff @(posedge i_sda or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stop_q <= 1'b0;
    else if (i_scl)
      stop_q <= ~stop_q;
  end

  // start level for the system side
  always_ff @(posedge i_scl or negedge i_rst_n)
  begin
    if (!i_rst_n)
      start_q <= 1'b0;
    else
      start_q <= (start_tg_q != start_ack_q) | start_q;
  end

  // stop level tracked on scl; a change means the frame is over
  logic stop_ack_q;
  always_ff @(posedge i_scl or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stop_ack_q <= 1'b0;
    else
      stop_ack_q <= stop_q;
  end

  // (RULE8) sample one bit per scl rise
  // (RULE11) idle ignores the clock until start; (RULE12) compare per bit
  always_ff @(posedge i_scl or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= PVPS_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      is_addr_q <= 1'b0;
      start_ack_q <= 1'b0;
      cmd_tgl_q <= 1'b0;
      cmd_q <= 8'h00;
    end
    else if (start_tg_q != start_ack_q)
    begin
      // (RULE18) start drops any partial byte; first address bit is this edge
      start_ack_q <= start_tg_q;
      sh_q <= {7'h00, i_sda};
      cnt_q <= 4'h1;
      state_q <= (i_sda == my_addr[6]) ? PVPS_ADDR : PVPS_IDLE;
    end
    else if (stop_q != stop_ack_q)
      // (RULE18) stop drops a partial byte
      state_q <= PVPS_IDLE;
    else
    begin
      unique case (state_q)
        PVPS_IDLE:
          cnt_q <= 4'h0;
        PVPS_ADDR:
        begin
          sh_q <= {sh_q[6:0], i_sda};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'h7)
          begin
            // (RULE13) (RULE17) write only; a read bit gets no acknowledge
            is_addr_q <= 1'b1;
            state_q <= i_sda ? PVPS_IDLE : PVPS_ACK;
          end
          // (RULE12) first mismatch goes idle
          else if (i_sda != my_addr[3'h6 - cnt_q[2:0]])
            state_q <= PVPS_IDLE;
        end
        PVPS_DATA:
        begin
          sh_q <= {sh_q[6:0], i_sda};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `PVPS_BYTE_BITS - 4'h1)
          begin
            is_addr_q <= 1'b0;
            state_q <= PVPS_ACK;
            // (RULE18) byte complete; published at its acknowledge
            cmd_q <= {sh_q[6:0], i_sda};
            cmd_tgl_q <= ~cmd_tgl_q;
          end
        end
        PVPS_ACK:
        begin
          // (RULE3) one command byte per frame; after it, go idle until the next start
          cnt_q <= 4'h0;
          state_q <= is_addr_q ? PVPS_DATA : PVPS_IDLE;
        end
        default:
          state_q <= PVPS_IDLE;
      endcase
    end
  end

  // (RULE4) pull sda low across the ninth clock; changes on scl fall
  // (RULE2) only sda is ever driven, never scl
  always_ff @(negedge i_scl or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sda_oe_q <= 1'b0;
    else
      sda_oe_q <= (state_q == PVPS_ACK) && (stop_q == stop_ack_q);
  end

  // (RULE4) acknowledge held while ack slot clock is high
  AST_ACK_HELD: // RULE4
  assert property (@(posedge i_scl) disable iff (!i_rst_n)
    (state_q == PVPS_ACK && $past(state_q) != PVPS_ACK) |-> sda_oe_q)
    else $error("acknowledge not driven in ninth clock");

  // (RULE17) read direction never leads to acknowledge
  AST_NO_READ_ACK: // RULE17
  assert property (@(posedge i_scl) disable iff (!i_rst_n)
    (state_q == PVPS_ADDR && cnt_q == 4'h7 && i_sda
     && start_tg_q == start_ack_q && stop_q == stop_ack_q)
    |=> state_q == PVPS_IDLE)
    else $error("read request was not refused");

  // (RULE18) command toggles only on entry to data acknowledge
  AST_CMD_ON_ACK: // RULE18
  assert property (@(posedge i_scl) disable iff (!i_rst_n)
    $changed(cmd_tgl_q) |-> state_q == PVPS_ACK && !is_addr_q)
    else $error("command published outside its acknowledge");
endmodule : pvps_rx

/* pvps_top.sv */
// supply-programming serial slave: bus front end plus setting registers
// Summary of operation
// (RULE1) serial interface runs only when powered and enabled
// (RULE2) slave only; never drives the clock
// (RULE3) master sends start, address, one command, stop
// (RULE4) device pulls data low on ninth clock
// (RULE5) bit five picks core or sim target
// (RULE6) core 25 mV code steps; sim two-bit level
// (RULE7) power-up core code 11000, sim off
// (RULE8) one bit per clock; data stable while high
// (RULE9) start is fall, stop is rise, clock high
// (RULE10) master ends with not-acknowledge then stop
// (RULE11) ignore bus after stop or wrong address
// (RULE12) compare address bits as they arrive
// (RULE13) direction bit must be zero, write only
// (RULE14) address bit one follows the strap pin
// (RULE15) master retries when acknowledge is missing
// (RULE16) manual reset restores core default, sim off
// (RULE17) read direction gets no acknowledge
// (RULE18) apply only complete acknowledged command bytes; switching the interface off after an odd command count writes core 00000
// assumes the bus clock is unrelated to I_SYS_CLK; outputs are in I_SYS_CLK domain
`timescale 1ns/1ns
`include "pvps_defines.svh"
module pvps_top
  import pvps_pkg::*;
(
  // system clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // serial bus: clock input only, data as open-drain triple
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // power and enables
  input wire logic I_UVLO_OK,
  input wire logic [5:0] I_REGULATOR_ENABLE_INPUTS,
  input wire logic I_MANUAL_RESET_INPUT_N,
  input wire logic I_ADDRESS_SELECT_PIN,
  // supply settings
  output logic [4:0] O_CORE_SUPPLY_CODE,
  output logic [1:0] O_SIM_SUPPLY_CODE,
  output logic O_IF_ACTIVE
);
  pvps_link_if lnk ();
  logic [1:0] uv_s_q;     // uvlo sync
  logic [1:0] en_s_q;     // any-enable sync
  logic [1:0] mr_s_q;     // manual reset sync (active low)
  logic [1:0] strap_s_q;  // strap sync
  logic [2:0] tg_s_q;     // command toggle sync plus edge stage
  logic active_q;         // interface powered
  logic strap_q;          // strap caught while interface off
  logic rx_rst_n;         // receiver reset, released only while active
  logic sda_oe;
  logic [4:0] core_q;
  logic [1:0] sim_q;
  logic oe_q;

  // two-stage synchronisers for pins
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      uv_s_q <= 2'h0;
      en_s_q <= 2'h0;
      mr_s_q <= 2'h3;
      strap_s_q <= 2'h0;
    end
    else
    begin
      uv_s_q <= {uv_s_q[0], I_UVLO_OK};
      en_s_q <= {en_s_q[0], |I_REGULATOR_ENABLE_INPUTS};
      mr_s_q <= {mr_s_q[0], I_MANUAL_RESET_INPUT_N};
      strap_s_q <= {strap_s_q[0], I_ADDRESS_SELECT_PIN};
    end
  end

  // (RULE1) interface powered only above lockout with an enable high
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      active_q <= 1'b0;
    else
      active_q <= uv_s_q[1] & en_s_q[1];
  end

  // (RULE14) strap caught while the receiver is held, so it is stable to it
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      strap_q <= 1'b0;
    else if (!active_q)
      strap_q <= strap_s_q[1];
  end

  // receiver held in reset while powered down; a register drives it
  assign rx_rst_n = active_q;

  pvps_rx u_rx (
    .i_scl(I_SCL),
    .i_rst_n(rx_rst_n),
    .i_sda(I_SDA),
    .i_strap(strap_q),
    .o_sda_oe(sda_oe),
    .lnk(lnk.rx)
  );

  // command toggle crossing: two flops, then an edge stage
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      tg_s_q <= 3'h0;
    else
      tg_s_q <= {tg_s_q[1:0], lnk.cmd_tgl};
  end

  // (RULE7) power-up defaults; (RULE16) manual reset restores them
  // (RULE5) target bit picks the register; (RULE6) code field widths
  // the byte is stable for many bus clocks after the toggle, so sampling is safe
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      core_q <= `PVPS_CORE_RST;
      sim_q <= `PVPS_SIM_RST;
    end
    else if (!mr_s_q[1])
    begin
      core_q <= `PVPS_CORE_RST;
      sim_q <= `PVPS_SIM_RST;
    end
    else if (tg_s_q[2] != tg_s_q[1])
    begin
      if (lnk.cmd_byte[`PVPS_TGT_BIT])
        sim_q <= lnk.cmd_byte[1:0];
      else
        core_q <= lnk.cmd_byte[4:0];
    end
  end

  // open-drain output: stays low level, enable carries the drive
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      oe_q <= 1'b0;
    else
      oe_q <= sda_oe & active_q;
  end

  assign O_SDA = 1'b0;
  assign O_SDA_OE = oe_q;
  assign O_CORE_SUPPLY_CODE = core_q;
  assign O_SIM_SUPPLY_CODE = sim_q;
  assign O_IF_ACTIVE = active_q;

  // (RULE16) manual reset forces defaults next cycle
  AST_MR_DEFAULT: // RULE16
  assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    !mr_s_q[1] |=> core_q == 5'h18 && sim_q == 2'h0)
    else $error("manual reset did not restore defaults");

  // (RULE5) core write leaves sim untouched
  AST_CORE_ONLY: // RULE5
  assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (mr_s_q[1] && tg_s_q[2] != tg_s_q[1] && !lnk.cmd_byte[5])
    |=> sim_q == $past(sim_q) && core_q == $past(lnk.cmd_byte[4:0]))
    else $error("core command mis-applied");

  // (RULE1) no acknowledge drive while powered down
  AST_OFF_QUIET: // RULE1
  assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    !active_q |=> !oe_q)
    else $error("data driven while interface off");
endmodule : pvps_top

/* pvps_master.sv */
// bus master model: drives the serial clock and an open-drain data line
// assumes i_lclk is the 64 ns link tick and i_sda_oe comes from the slave
`timescale 1ns/1ns
module pvps_master
(
  // link tick and slave data pull-down
  input wire logic i_lclk,
  input wire logic i_sda_oe,
  // bus lines as seen on the wires
  output logic o_scl,
  output logic o_sda
);
  logic drv_low; // master pulls data low
  // pull-up: a released line reads high
  assign o_sda = ~(drv_low | i_sda_oe);
  // only the master makes the clock; it stands high between frames
  initial o_scl = 1'b1;
  initial drv_low = 1'b0;
  // wait n link ticks
  task automatic tick(input int n);
    repeat (n) @(posedge i_lclk);
  endtask : tick
  // start: data falls while clock high
  task automatic start();
    tick(2);
    drv_low <= 1'b1;
    tick(2);
    o_scl <= 1'b0;
  endtask : start
  // one bit per clock, msb first, changed only while clock low
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      tick(2);
      drv_low <= ~b[7-i];
      tick(2);
      o_scl <= 1'b1;
      tick(4);
      o_scl <= 1'b0;
    end
  endtask : bits
  // ninth clock: release data and sample the answer
  task automatic ack(output logic a);
    tick(2);
    drv_low <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    a = ~o_sda;
    tick(2);
    o_scl <= 1'b0;
  endtask : ack
  // stop: data rises while clock high, bus freed
  task automatic stop();
    tick(2);
    drv_low <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    drv_low <= 1'b0;
    tick(4);
  endtask : stop
endmodule : pvps_master

/* test_pmic_voltage_program_slave.sv */
// self-checking bench of the supply-programming serial slave
// assumes pvps_master sits on the bus; bus timing is slow next to I_SYS_CLK
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_pmic_voltage_program_slave;
  logic sys_clk = 1'b0; // 25 MHz
  logic lclk = 1'b0; // 64 ns link tick, own phase
  logic rst_n = 1'b0;
  logic uvlo = 1'b0;
  logic mr_n = 1'b1;
  logic strap = 1'b0;
  logic [5:0] en = 6'h00;
  logic aa; // address acknowledged
  logic ad; // data acknowledged
  wire scl, sda, sda_o, sda_oe, active;
  wire [4:0] core;
  wire [1:0] sim;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  // clocks
  initial forever #20 sys_clk = ~sys_clk;
  initial
  begin
    #13;
    forever #32 lclk = ~lclk;
  end
  pvps_top DUT (.I_SYS_CLK(sys_clk), .I_RESETN(rst_n), .I_SCL(scl), .I_SDA(sda),
    .O_SDA(sda_o), .O_SDA_OE(sda_oe), .I_UVLO_OK(uvlo), .I_REGULATOR_ENABLE_INPUTS(en),
    .I_MANUAL_RESET_INPUT_N(mr_n), .I_ADDRESS_SELECT_PIN(strap),
    .O_CORE_SUPPLY_CODE(core), .O_SIM_SUPPLY_CODE(sim), .O_IF_ACTIVE(active));
  pvps_master m (.i_lclk(lclk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  // verdict and end of run
  task finish_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // hang guard: the run needs well under this many cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      finish_test();
    end
  end
  task clks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : clks
  // one frame: address, n data bits, ack only after a whole byte, stop
  task frame(input logic [7:0] a, input logic [7:0] d, input int n);
    m.start();
    m.bits(a, 8);
    m.ack(aa);
    m.bits(d, n);
    ad = 1'b0;
    if (n == 8)
      m.ack(ad);
    m.stop();
    clks(6);
  endtask : frame
  // defaults, then power gating of the interface
  task t_power();
    `CHK(core, 5'h18)
    `CHK(sim, 2'h0)
    `CHK(sda_o, 1'b0)
    frame(8'h28, 8'h05, 8);
    `CHK(aa, 1'b0)
    @(posedge sys_clk) uvlo <= 1'b1;
    clks(8);
    `CHK(active, 1'b0)
    @(posedge sys_clk) en <= 6'h20;
    clks(5);
    `CHK(active, 1'b1)
  endtask : t_power
  // core codes at both ends, top bits set to show they are ignored
  task automatic t_core();
    logic [7:0] v [0:2] = '{8'h00, 8'hDF, 8'h4A};
    for (int i = 0; i < 3; i++)
    begin
      frame(8'h28, v[i], 8);
      `CHK(aa, 1'b1)
      `CHK(ad, 1'b1)
      `CHK(core, v[i][4:0])
      `CHK(sim, 2'h0)
      `CHK(sda, 1'b1)
    end
  endtask : t_core
  // every sim level with ignored bits 4 to 2 high and bits 7 and 6 low
  task automatic t_sim();
    for (int i = 0; i < 4; i++)
    begin
      frame(8'h28, 8'h3C | 8'(i), 8);
      `CHK(sim, 2'(i))
      `CHK(core, 5'h0A)
    end
  endtask : t_sim
  // wrong strap bit, read direction, early address mismatch
  task t_refuse();
    frame(8'h2A, 8'h01, 8);
    `CHK(aa, 1'b0)
    `CHK(ad, 1'b0)
    frame(8'h29, 8'h01, 8);
    `CHK(aa, 1'b0)
    `CHK(ad, 1'b0)
    frame(8'h08, 8'h01, 8);
    `CHK(ad, 1'b0)
    `CHK(core, 5'h0A)
  endtask : t_refuse
  // cut-short byte is dropped; a second byte in one frame is not taken
  task t_partial();
    logic x;
    frame(8'h28, 8'h07, 5);
    `CHK(aa, 1'b1)
    `CHK(core, 5'h0A)
    m.start();
    m.bits(8'h28, 8);
    m.ack(aa);
    m.bits(8'h03, 8);
    m.ack(ad);
    m.bits(8'h11, 8);
    m.ack(x);
    m.stop();
    clks(6);
    `CHK(ad, 1'b1)
    `CHK(x, 1'b0)
    `CHK(core, 5'h03)
  endtask : t_partial
  // strap change made while the interface is off is taken once it is back on
  task t_strap();
    @(posedge sys_clk) en <= 6'h00;
    clks(5);
    `CHK(active, 1'b0)
    @(posedge sys_clk) strap <= 1'b1;
    clks(2);
    @(posedge sys_clk) en <= 6'h01;
    clks(5);
    frame(8'h28, 8'h12, 8);
    `CHK(aa, 1'b0)
    frame(8'h2A, 8'h12, 8);
    `CHK(aa, 1'b1)
    `CHK(core, 5'h12)
  endtask : t_strap
  // manual reset restores the defaults
  task t_mr();
    frame(8'h2A, 8'h23, 8);
    `CHK(sim, 2'h3)
    @(posedge sys_clk) mr_n <= 1'b0;
    clks(2);
    @(posedge sys_clk) mr_n <= 1'b1;
    clks(2);
    `CHK(core, 5'h18)
    `CHK(sim, 2'h0)
  endtask : t_mr
  // main sequence
  initial
  begin
    clks(2);
    @(posedge sys_clk) rst_n <= 1'b1;
    clks(2);
    t_power();
    t_core();
    t_sim();
    t_refuse();
    t_partial();
    t_strap();
    t_mr();
    finish_test();
  end
endmodule : test_pmic_voltage_program_slave
